// [lat_consts.svh]
// constants for the logic analyzer trigger block
`ifndef LAT_CONSTS_SVH
`define LAT_CONSTS_SVH
`define LAT_NUM_IN        8
`define LAT_CLK_NS        10
`define LAT_AUTO_WAIT_NS  100000
`define LAT_CAP_LEN       16'h0010
`define LAT_ROLL_MIN_US   32'h00004E20
`define LAT_ADDR_CTRL     12'h000
`define LAT_ADDR_COND     12'h004
`define LAT_ADDR_TBASE    12'h008
`define LAT_ADDR_STAT     12'h00C
`define LAT_CTRL_MODE_LO  0
`define LAT_CTRL_MODE_HI  1
`define LAT_CTRL_SRC      2
`define LAT_CTRL_RUN      3
`define LAT_CTRL_STOP     4
`define LAT_STAT_OVR      4
`define LAT_COND_W        3
`define LAT_COND_RST      24'h000000
`define LAT_TBASE_RST     32'h000003E8
`endif

// [lat_host.sv]
// host side model that sinks the sample stream and keeps tallies
`timescale 1ns/10ps
`default_nettype none
module lat_host
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // sample stream
   input  wire logic              smp_valid,
   input  wire lat_pkg::lat_smp_t smp,
   output logic                   smp_ready,
   // control and tallies
   input  wire logic              slow,
   output int                     n_smp,
   output int                     n_last,
   output logic [7:0]             last_data
);
   // every emitted sample is tallied, even a dropped one, so a stall never hides output
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         n_smp <= 0;
         n_last <= 0;
         last_data <= 8'h00;
         smp_ready <= 1'b1;
      end
      else
      begin
         smp_ready <= slow ? 1'($urandom) : 1'b1;
         if (smp_valid)
         begin
            n_smp <= n_smp + 1;
            n_last <= n_last + int'(smp.last);
            last_data <= smp.data;
         end
      end
   end
endmodule
`default_nettype wire

// [lat_pkg.sv]
// types for the logic analyzer trigger block
package lat_pkg;
   typedef enum logic [1:0] {MODE_AUTO, MODE_NORMAL, MODE_SINGLE, MODE_ROLL} lat_mode_t;
   typedef enum logic [2:0] {COND_X, COND_RISE, COND_FALL, COND_LOW, COND_HIGH} lat_cond_t;
   typedef enum logic [1:0] {ST_STOPPED, ST_ARMED, ST_CAPTURE, ST_ROLL} lat_state_t;
   typedef struct packed
   {
      logic       last;
      logic [7:0] data;
   } lat_smp_t;
endpackage

// [lat_trigger.sv]
// trigger and acquisition control for an eight input logic analyzer
//
// What this block does
// - with the digital source, a trigger fires only when all eight inputs meet their own condition in the same sample.
// - each input condition is one of ignore, rising edge, falling edge, low or high.
// - auto mode captures on every trigger and, when triggers stop, still delivers a capture.
// - normal mode delivers a capture only on a trigger and sends nothing otherwise.
// - single mode waits for one trigger, delivers that capture and then stops until re-armed.
// - rolling mode streams every sample to the host as it arrives until stopped.
// - with analog and digital capture together exactly one trigger source, chosen by the host, is armed.
// - all eight inputs are sampled together at 100 MS/s and the trigger is evaluated on those samples.
// - auto is the mode after reset, and rolling is allowed only at 20 ms/div or slower.
`timescale 1ns/10ps
`default_nettype none
`include "lat_consts.svh"
module lat_trigger
#(
   parameter int AUTO_WAIT_CYC = `LAT_AUTO_WAIT_NS / `LAT_CLK_NS
)
(
   // clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // probe pins and analog comparator
   input  wire logic [7:0]          la_in,
   input  wire logic                ana_trig,
   // sample stream to host
   output logic                     smp_valid,
   output lat_pkg::lat_smp_t        smp,
   input  wire logic                smp_ready,
   // status
   output logic                     running
);
   localparam int AW = $clog2(AUTO_WAIT_CYC + 1);

   // pin synchronisers: bit 8 carries the analog comparator
   logic [8:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q   <= 9'h000;
         s2_q   <= 9'h000;
         s3_q   <= 9'h000;
         filt_q <= 9'h000;
         prev_q <= 9'h000;
      end
      else
      begin
         s1_q   <= {ana_trig, la_in};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
         prev_q <= filt_q;
      end
   end
   // a change counts only once the second and third stage agree
   assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

   // registers
   lat_pkg::lat_mode_t  mode_q;
   lat_pkg::lat_state_t st_q, st_d;
   logic        src_q, ovr_q;
   logic [23:0] cond_q;
   logic [31:0] tbase_q;
   logic [15:0] cnt_q, cnt_d;
   logic [AW-1:0] wait_q, wait_d;

   // bus decode, zero wait states
   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire hit_ctrl = paddr == `LAT_ADDR_CTRL;
   wire hit_cond = paddr == `LAT_ADDR_COND;
   wire hit_tb   = paddr == `LAT_ADDR_TBASE;
   wire hit_st   = paddr == `LAT_ADDR_STAT;
   wire mapped   = hit_ctrl | hit_cond | hit_tb | hit_st;
   wire run_wr   = wr & hit_ctrl & pwdata[`LAT_CTRL_RUN];
   wire stop_wr  = wr & hit_ctrl & pwdata[`LAT_CTRL_STOP];
   wire ovr_clr  = wr & hit_st & pwdata[`LAT_STAT_OVR];
   // slow timebases only may roll
   wire roll_ok = tbase_q >= `LAT_ROLL_MIN_US;
   wire want_roll = (mode_q == lat_pkg::MODE_ROLL) & roll_ok;
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata  = !acc ? 32'h00000000 :
                    hit_ctrl ? {27'h0000000, 1'b0, 1'b0, src_q, mode_q} :
                    hit_cond ? {8'h00, cond_q} :
                    hit_tb   ? tbase_q :
                    hit_st   ? {27'h0000000, ovr_q, roll_ok, 1'b0, st_q} : 32'h00000000;

   // per input condition match
   logic [7:0] in_ok;
   genvar gi;
   generate
      for (gi = 0; gi < `LAT_NUM_IN; gi++)
      begin : g_in
         wire [2:0] c = cond_q[gi*`LAT_COND_W +: `LAT_COND_W];
         wire rise = filt_q[gi] & ~prev_q[gi];
         wire fall = ~filt_q[gi] & prev_q[gi];
         assign in_ok[gi] = (c == lat_pkg::COND_X)    |
                            ((c == lat_pkg::COND_RISE) & rise) |
                            ((c == lat_pkg::COND_FALL) & fall) |
                            ((c == lat_pkg::COND_LOW)  & ~filt_q[gi]) |
                            ((c == lat_pkg::COND_HIGH) & filt_q[gi]);
      end
   endgenerate
   wire dig_hit = &in_ok;
   // one source only: the other is ignored entirely
   wire trig    = src_q ? filt_q[8] : dig_hit;
   wire timeout = (mode_q == lat_pkg::MODE_AUTO) & (wait_q == AW'(AUTO_WAIT_CYC - 1));
   wire cap_end = cnt_q == `LAT_CAP_LEN - 16'h0001;

   // register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q  <= lat_pkg::MODE_AUTO;
         src_q   <= 1'b0;
         cond_q  <= `LAT_COND_RST;
         tbase_q <= `LAT_TBASE_RST;
      end
      else if (wr)
      begin
         if (hit_ctrl)
         begin
            mode_q <= lat_pkg::lat_mode_t'(pwdata[`LAT_CTRL_MODE_HI:`LAT_CTRL_MODE_LO]);
            src_q  <= pwdata[`LAT_CTRL_SRC];
         end
         if (hit_cond)
            cond_q <= pwdata[23:0];
         if (hit_tb)
            tbase_q <= pwdata;
      end
   end

   // acquisition sequencer
   always_comb
   begin
      st_d   = st_q;
      cnt_d  = 16'h0000;
      wait_d = '0;
      case (st_q)
         lat_pkg::ST_STOPPED:
            if (run_wr)
               st_d = want_roll ? lat_pkg::ST_ROLL : lat_pkg::ST_ARMED;
         lat_pkg::ST_ARMED:
         begin
            wait_d = wait_q + AW'(1);
            if (want_roll)
               st_d = lat_pkg::ST_ROLL;
            else if (trig | timeout)
               st_d = lat_pkg::ST_CAPTURE;
         end
         lat_pkg::ST_CAPTURE:
         begin
            cnt_d = cnt_q + 16'h0001;
            if (cap_end)
               st_d = (mode_q == lat_pkg::MODE_SINGLE) ? lat_pkg::ST_STOPPED : lat_pkg::ST_ARMED;
         end
         lat_pkg::ST_ROLL:
            if (!want_roll)
               st_d = lat_pkg::ST_ARMED;
         default:
            st_d = lat_pkg::ST_STOPPED;
      endcase
      if (stop_wr)
         st_d = lat_pkg::ST_STOPPED;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q   <= lat_pkg::ST_ARMED;
         cnt_q  <= 16'h0000;
         wait_q <= '0;
      end
      else
      begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         wait_q <= wait_d;
      end
   end

   // sample output; a stalled host loses samples and sets the overrun flag
   wire emit = (st_q == lat_pkg::ST_CAPTURE) | (st_q == lat_pkg::ST_ROLL);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         smp_valid <= 1'b0;
         smp       <= '0;
         ovr_q     <= 1'b0;
      end
      else
      begin
         smp_valid <= emit;
         smp.data  <= filt_q[7:0];
         smp.last  <= (st_q == lat_pkg::ST_CAPTURE) & cap_end;
         ovr_q     <= (smp_valid & ~smp_ready) | (ovr_q & ~ovr_clr); // set wins
      end
   end
   assign running = st_q != lat_pkg::ST_STOPPED;

   // checks
   sequence s_trig_armed;
      st_q == lat_pkg::ST_ARMED && !want_roll && !stop_wr && trig;
   endsequence
   sequence s_capture_run;
      st_q == lat_pkg::ST_CAPTURE ##1 smp_valid;
   endsequence
   trig_starts_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_trig_armed |=> s_capture_run) else $error("trigger did not start capture");
   all_inputs_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == lat_pkg::ST_ARMED && st_d == lat_pkg::ST_CAPTURE && !src_q && !timeout |-> &in_ok)
      else $error("capture began without every input matching");
   rise_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
      cond_q[2:0] == 3'h1 && in_ok[0] |-> filt_q[0] && !prev_q[0]) else $error("rise matched without edge");
   high_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
      cond_q[2:0] == 3'h4 |-> in_ok[0] == filt_q[0]) else $error("high level mismatch");
   // checker helper: samples delivered so far in the current run; a stop may cut a capture at any point
   logic [15:0] n_cap_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         n_cap_q <= 16'h0000;
      else if (!smp_valid | smp.last)
         n_cap_q <= 16'h0000;
      else
         n_cap_q <= n_cap_q + 16'h0001;
   end
   cap_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      smp_valid && smp.last |-> n_cap_q == `LAT_CAP_LEN - 16'h0001)
      else $error("capture length wrong");
   normal_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == lat_pkg::MODE_NORMAL && st_q == lat_pkg::ST_ARMED && !trig |=> st_q != lat_pkg::ST_CAPTURE)
      else $error("normal mode captured without trigger");
   single_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == lat_pkg::ST_CAPTURE && cap_end && mode_q == lat_pkg::MODE_SINGLE |=> st_q == lat_pkg::ST_STOPPED)
      else $error("single mode did not stop");
   roll_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == lat_pkg::ST_ROLL |-> $past(tbase_q) >= `LAT_ROLL_MIN_US) else $error("roll below 20 ms/div");
   roll_stream_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == lat_pkg::ST_ROLL |=> smp_valid && smp.data == $past(filt_q[7:0])) else $error("roll sample missing");
   src_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      src_q |-> trig == filt_q[8]) else $error("digital pattern used while analog armed");
   edge_prev_a: assert property (@(posedge pclk) disable iff (!presetn)
      prev_q == $past(filt_q)) else $error("previous sample stale");
endmodule
`default_nettype wire

// [logic_analyzer_trigger_bench.sv]
// self-checking bench for the trigger block
`timescale 1ns/10ps
`default_nettype none
module logic_analyzer_trigger_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, smp_valid, smp_ready, running, ana_trig, slow, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdq;
   logic [7:0] la_in, last_data;
   lat_pkg::lat_smp_t smp;
   int n_smp, n_last, s0, l0, mismatches, n_tests;
   logic pre;

   lat_trigger #(.AUTO_WAIT_CYC(20)) lat_trigger_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .la_in(la_in), .ana_trig(ana_trig), .smp_valid(smp_valid), .smp(smp),
      .smp_ready(smp_ready), .running(running));
   lat_host lat_host_inst (.pclk(pclk), .presetn(presetn), .smp_valid(smp_valid), .smp(smp),
      .smp_ready(smp_ready), .slow(slow), .n_smp(n_smp), .n_last(n_last), .last_data(last_data));

   // 100 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // reference model: a pin value reaches the sample word five edges later, a capture holds 16 samples
   logic [7:0] pin_hist [$];
   int run_n;
   always @(posedge pclk)
   begin
      if (!presetn)
      begin
         pin_hist.delete();
         run_n = 0;
      end
      else
      begin
         pin_hist.push_back(la_in);
         run_n = smp_valid ? run_n + 1 : 0;
         if (pin_hist.size() > 6)
            void'(pin_hist.pop_front());
         if (smp_valid && pin_hist.size() == 6)
            chk("sample data", smp.data, pin_hist[0]);
         if (smp_valid && smp.last)
            chk("capture length", run_n, 16);
      end
   end

   // one apb transfer; a free cycle first so psel never changes twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdq = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // stop, load a condition word, settle the pins, then snapshot the tallies
   task automatic setup(input logic [31:0] cond, input logic [7:0] pins);
      apb(1'b1, 12'h000, 32'h00000010);
      apb(1'b1, 12'h004, cond);
      la_in <= pins;
      repeat (10) @(posedge pclk);
      s0 = n_smp;
      l0 = n_last;
   endtask

   // watchdog: the tests take under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      report_and_stop();
   end

   initial
   begin
      {presetn, psel, penable, pwrite, ana_trig, slow} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      la_in = 8'h00;
      mismatches = 0;
      n_tests = 0;
      void'($urandom(25391));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl reset", rdq, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk("roll allowed", rdq[3], 1'b0);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped rd", rdq, 32'h0);
      chk("unmapped err", err, 1'b1);
      $display("test reset done");
      // each edge and level condition on input 3, others ignored and random
      for (int c = 1; c <= 4; c++)
      begin
         pre = (c == 2 || c == 3);
         setup(32'(c) << 9, (8'($urandom) & 8'hF7) | {4'h0, pre, 3'h0});
         apb(1'b1, 12'h000, 32'h0000000A);
         repeat (40) @(posedge pclk);
         chk("single idle", n_smp - s0, 0);
         la_in[3] <= ~pre;
         repeat (40) @(posedge pclk);
         chk("single count", n_smp - s0, 16);
         chk("single last", n_last - l0, 1);
         chk("single data", last_data, la_in);
         apb(1'b0, 12'h00C, 32'h0);
         chk("single stopped", rdq[1:0], 2'h0);
         chk("single running", running, 1'b0);
      end
      $display("test single done");
      setup(32'h4, 8'($urandom) & 8'hFE);
      apb(1'b1, 12'h000, 32'h00000009);
      repeat (60) @(posedge pclk);
      chk("normal idle", n_smp - s0, 0);
      la_in[0] <= 1'b1;
      repeat (40) @(posedge pclk);
      chk("normal trig", n_last != l0, 1);
      setup(32'h4, 8'h00);
      apb(1'b1, 12'h000, 32'h00000008);
      repeat (100) @(posedge pclk);
      chk("auto forced", n_last != l0, 1);
      $display("test normal auto done");
      setup(32'h0, 8'($urandom));
      apb(1'b1, 12'h000, 32'h0000000D);
      repeat (40) @(posedge pclk);
      chk("analog idle", n_smp - s0, 0);
      ana_trig <= 1'b1;
      repeat (10) @(posedge pclk);
      ana_trig <= 1'b0;
      repeat (30) @(posedge pclk);
      chk("analog trig", n_last != l0, 1);
      $display("test analog done");
      setup(32'h0, 8'($urandom));
      apb(1'b1, 12'h008, 32'h00004E20);
      apb(1'b0, 12'h00C, 32'h0);
      chk("roll allowed", rdq[3], 1'b1);
      slow <= 1'b1;
      s0 = n_smp;
      apb(1'b1, 12'h000, 32'h0000000B);
      repeat (50) @(posedge pclk);
      chk("roll stream", n_smp - s0 >= 40, 1);
      chk("roll running", running, 1'b1);
      chk("roll no last", n_last - l0, 0);
      apb(1'b0, 12'h00C, 32'h0);
      chk("roll state ovr", {rdq[4], rdq[1:0]}, 3'h7);
      apb(1'b1, 12'h000, 32'h00000010);
      slow <= 1'b0;
      repeat (5) @(posedge pclk);
      s0 = n_smp;
      repeat (20) @(posedge pclk);
      chk("roll stopped", n_smp - s0, 0);
      apb(1'b1, 12'h00C, 32'h00000010);
      apb(1'b0, 12'h00C, 32'h0);
      chk("ovr cleared", rdq[4], 1'b0);
      $display("test roll done");
      report_and_stop();
   end
endmodule
`default_nettype wire
